//--- rtl/velocity_mode_pkg.sv
// constants and carrier types for the velocity mode selector
package velocity_mode_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_GLOBAL_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_QUIET_LIMIT   = 8'h04;
  localparam logic [7:0] ADDR_HIGH_LIMIT    = 8'h08;
  localparam logic [7:0] ADDR_LOAD_LIMIT    = 8'h0c;
  localparam logic [7:0] ADDR_CURRENT       = 8'h10;
  localparam logic [7:0] ADDR_STEP_INTERVAL = 8'h14;
  localparam logic [7:0] ADDR_STATUS        = 8'h18;

  // ************************************************************
  // field layouts
  // ************************************************************
  localparam int INTERVAL_W   = 20;
  localparam int CURRENT_W    = 5;
  localparam int MRES_W       = 4;
  localparam int GC_SMALL_HYS = 0;
  localparam int GC_EXT_STEP  = 1;
  localparam int GC_MRES_LSB  = 4;
  localparam int CUR_RUN_LSB  = 0;
  localparam int CUR_HOLD_LSB = 8;
  localparam int ST_STST      = 0;
  localparam int ST_QUIET     = 1;
  localparam int ST_HIGH      = 2;
  localparam int ST_LOAD      = 3;

  // ************************************************************
  // reset values, hysteresis shifts, timing
  // ************************************************************
  localparam logic [INTERVAL_W-1:0] LIMIT_RST   = 20'h00000;
  localparam logic [CURRENT_W-1:0]  RUN_RST     = 5'h1f;
  localparam logic [CURRENT_W-1:0]  HOLD_RST    = 5'h08;
  localparam logic [MRES_W-1:0]     MRES_MAX    = 4'h8;
  localparam int                    HYS_SHIFT_L = 4;
  localparam int                    HYS_SHIFT_S = 5;
  localparam int                    STST_CLKS   = 1 << 20;
  localparam logic [1:0]            RESP_OKAY   = 2'b00;
  localparam logic [1:0]            RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [MRES_W-1:0] mres;
    logic              ext_step;
    logic              small_hys;
  } gcfg_t;

  typedef struct packed {
    logic [CURRENT_W-1:0] hold;
    logic [CURRENT_W-1:0] run;
  } current_cfg_t;

endpackage

//--- rtl/hys_compare.sv
// one interval threshold comparator with selectable hysteresis
`timescale 1ns/1ps
`default_nettype none
module hys_compare
  import velocity_mode_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  upd,
  input  wire logic [INTERVAL_W-1:0] interval,
  input  wire logic [INTERVAL_W-1:0] limit,
  input  wire logic                  small_hys,
  output logic                       above_ff
);

  logic [INTERVAL_W-1:0] on_level;
  logic                  nxt_above;

  // ************************************************************
  // compare: short interval means fast motor
  // ************************************************************
  always_comb begin
    // switch-on needs a shorter interval than switch-off, so jitter
    // around the limit does not chatter
    on_level = limit - (small_hys ? (limit >> HYS_SHIFT_S)
                                  : (limit >> HYS_SHIFT_L));
    nxt_above = above_ff;
    if (upd) begin
      if (interval < on_level)
        nxt_above = 1'b1;
      else if (interval >= limit)
        nxt_above = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      above_ff <= 1'b0;
    else
      above_ff <= nxt_above;
  end

  // ************************************************************
  // checks
  // ************************************************************
  turn_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    upd && interval < on_level |=> above_ff)
    else $error("comparator did not switch on below on level");
  hys_band_a: assert property (@(posedge aclk) disable iff (!aresetn)
    upd && above_ff && interval < limit |=> above_ff)
    else $error("comparator dropped inside hysteresis band");
  hys_frac_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(above_ff) |-> $past(interval) < $past(limit) -
      ($past(small_hys) ? ($past(limit) >> HYS_SHIFT_S)
                        : ($past(limit) >> HYS_SHIFT_L)))
    else $error("comparator rose without hysteresis margin");
  auto_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !upd |=> $stable(above_ff))
    else $error("comparator changed without a new measurement");

endmodule // hys_compare
`default_nettype wire

//--- rtl/velocity_mode_selector.sv
// velocity mode selector: step interval, thresholds, current level
//
// How it works
// - measure clocks between consecutive step pulses, source picked by ext_step
// - shift interval to 256-microstep resolution
// - compare interval against three programmed limits
// - hysteresis of 1/16 or 1/32 of the limit
// - small hysteresis bit selects 1/32 instead
// - standstill picks hold current, else run current
// - mode flags follow comparisons without software
// - standstill flag after fixed clocks without step
`timescale 1ns/1ps
`default_nettype none
module velocity_mode_selector
  import velocity_mode_pkg::*;
#(
  parameter int STST_COUNT = STST_CLKS
)(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 step_int,
  input  wire logic                 step_ext,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic                      stst_ff,
  output logic                      above_quiet_ff,
  output logic                      above_high_ff,
  output logic                      above_load_ff,
  output logic [CURRENT_W-1:0]      current_level_ff
);

  localparam int CNT_W = $clog2(STST_COUNT + 1);
  localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(STST_COUNT);
  localparam int NORM_W = ((CNT_W > INTERVAL_W) ? CNT_W : INTERVAL_W) + 1;
  localparam logic [INTERVAL_W-1:0] IV_MAX = '1;

  // ************************************************************
  // registers
  // ************************************************************
  gcfg_t                 gcfg_ff, nxt_gcfg;
  current_cfg_t          cur_ff, nxt_cur;
  logic [INTERVAL_W-1:0] quiet_ff, nxt_quiet;
  logic [INTERVAL_W-1:0] high_ff, nxt_high;
  logic [INTERVAL_W-1:0] load_ff, nxt_load;
  logic                  wr_en;
  logic                  wrdy_ff, nxt_wrdy;
  logic                  ardy_ff, nxt_ardy;
  logic                  bvalid_ff, nxt_bvalid;
  logic [1:0]            bresp_ff, nxt_bresp;
  logic                  rvalid_ff, nxt_rvalid;
  logic [1:0]            rresp_ff, nxt_rresp;
  logic [31:0]           rdata_ff, nxt_rdata;
  logic [31:0]           wmask;

  // ************************************************************
  // measurement state
  // ************************************************************
  logic [2:0]            ext_sync_ff;
  logic                  step_evt;
  logic [CNT_W-1:0]      cnt_ff, nxt_cnt;
  logic [INTERVAL_W-1:0] interval_ff, nxt_interval;
  logic                  upd_ff, nxt_upd;
  logic                  nxt_stst;
  logic [CURRENT_W-1:0]  nxt_level;
  logic [NORM_W-1:0]     norm_cnt;
  logic [MRES_W-1:0]     mres_eff;

  // ************************************************************
  // axi4-lite slave: both write channels taken together
  // ************************************************************
  assign wr_en = s_axi_awvalid && s_axi_wvalid && wrdy_ff;
  always_comb begin
    wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
             {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    nxt_gcfg   = gcfg_ff;
    nxt_cur    = cur_ff;
    nxt_quiet  = quiet_ff;
    nxt_high   = high_ff;
    nxt_load   = load_ff;
    nxt_bvalid = bvalid_ff && !s_axi_bready;
    nxt_bresp  = bresp_ff;
    nxt_wrdy   = s_axi_awvalid && s_axi_wvalid && !bvalid_ff && !wrdy_ff;
    if (wr_en) begin
      nxt_bvalid = 1'b1;
      nxt_bresp  = RESP_OKAY;
      case (s_axi_awaddr)
        ADDR_GLOBAL_CONFIG: begin
          if (s_axi_wstrb[0]) begin
            nxt_gcfg.small_hys = s_axi_wdata[GC_SMALL_HYS];
            nxt_gcfg.ext_step  = s_axi_wdata[GC_EXT_STEP];
            nxt_gcfg.mres = s_axi_wdata[GC_MRES_LSB +: MRES_W];
          end
        end
        ADDR_QUIET_LIMIT:
          nxt_quiet = (quiet_ff & ~wmask[INTERVAL_W-1:0]) |
                      (s_axi_wdata[INTERVAL_W-1:0] & wmask[INTERVAL_W-1:0]);
        ADDR_HIGH_LIMIT:
          nxt_high = (high_ff & ~wmask[INTERVAL_W-1:0]) |
                     (s_axi_wdata[INTERVAL_W-1:0] & wmask[INTERVAL_W-1:0]);
        ADDR_LOAD_LIMIT:
          nxt_load = (load_ff & ~wmask[INTERVAL_W-1:0]) |
                     (s_axi_wdata[INTERVAL_W-1:0] & wmask[INTERVAL_W-1:0]);
        ADDR_CURRENT: begin
          if (s_axi_wstrb[0])
            nxt_cur.run = s_axi_wdata[CUR_RUN_LSB +: CURRENT_W];
          if (s_axi_wstrb[1])
            nxt_cur.hold = s_axi_wdata[CUR_HOLD_LSB +: CURRENT_W];
        end
        ADDR_STEP_INTERVAL, ADDR_STATUS: ;
        default: nxt_bresp = RESP_SLVERR;
      endcase
    end
  end

  always_comb begin
    nxt_rvalid = rvalid_ff && !s_axi_rready;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_arvalid && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = RESP_OKAY;
      nxt_rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        ADDR_GLOBAL_CONFIG: begin
          nxt_rdata[GC_SMALL_HYS] = gcfg_ff.small_hys;
          nxt_rdata[GC_EXT_STEP]  = gcfg_ff.ext_step;
          nxt_rdata[GC_MRES_LSB +: MRES_W] = gcfg_ff.mres;
        end
        ADDR_QUIET_LIMIT:   nxt_rdata[INTERVAL_W-1:0] = quiet_ff;
        ADDR_HIGH_LIMIT:    nxt_rdata[INTERVAL_W-1:0] = high_ff;
        ADDR_LOAD_LIMIT:    nxt_rdata[INTERVAL_W-1:0] = load_ff;
        ADDR_CURRENT: begin
          nxt_rdata[CUR_RUN_LSB +: CURRENT_W]  = cur_ff.run;
          nxt_rdata[CUR_HOLD_LSB +: CURRENT_W] = cur_ff.hold;
        end
        ADDR_STEP_INTERVAL: nxt_rdata[INTERVAL_W-1:0] = interval_ff;
        ADDR_STATUS: begin
          nxt_rdata[ST_STST]  = stst_ff;
          nxt_rdata[ST_QUIET] = above_quiet_ff;
          nxt_rdata[ST_HIGH]  = above_high_ff;
          nxt_rdata[ST_LOAD]  = above_load_ff;
        end
        default: nxt_rresp = RESP_SLVERR;
      endcase
    end
    nxt_ardy = !nxt_rvalid;
  end

  assign s_axi_awready = wrdy_ff;
  assign s_axi_wready  = wrdy_ff;
  assign s_axi_arready = ardy_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gcfg_ff   <= '0;
      cur_ff    <= '{hold: HOLD_RST, run: RUN_RST};
      quiet_ff  <= LIMIT_RST;
      high_ff   <= LIMIT_RST;
      load_ff   <= LIMIT_RST;
      bvalid_ff <= 1'b0;
      wrdy_ff   <= 1'b0;
      ardy_ff   <= 1'b1;
      bresp_ff  <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else begin
      gcfg_ff   <= nxt_gcfg;
      cur_ff    <= nxt_cur;
      quiet_ff  <= nxt_quiet;
      high_ff   <= nxt_high;
      load_ff   <= nxt_load;
      bvalid_ff <= nxt_bvalid;
      wrdy_ff   <= nxt_wrdy;
      ardy_ff   <= nxt_ardy;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff  <= nxt_rresp;
      rdata_ff  <= nxt_rdata;
    end
  end

  // ************************************************************
  // step interval measurement
  // ************************************************************
  always_comb begin
    // coarser modes move further per step, so the raw count grows
    mres_eff = (gcfg_ff.mres > MRES_MAX) ? MRES_MAX : gcfg_ff.mres;
    // count is zero in the cycle after a step, so add that clock back
    norm_cnt = (NORM_W'(cnt_ff) + NORM_W'(1)) >> mres_eff;
    step_evt = gcfg_ff.ext_step ? (ext_sync_ff[1] && !ext_sync_ff[2])
                                : step_int;
    nxt_cnt      = cnt_ff;
    nxt_interval = interval_ff;
    nxt_upd      = 1'b0;
    if (step_evt) begin
      nxt_cnt = '0;
      nxt_upd = 1'b1;
      // a step out of standstill has no valid count, read as slowest
      nxt_interval = (cnt_ff == CNT_TOP || norm_cnt > NORM_W'(IV_MAX))
                     ? IV_MAX : norm_cnt[INTERVAL_W-1:0];
    end else if (cnt_ff != CNT_TOP) begin
      nxt_cnt = cnt_ff + 1'b1;
      if (nxt_cnt == CNT_TOP) begin
        // stopped motor reads as slowest, so fast modes drop out
        nxt_interval = IV_MAX;
        nxt_upd      = 1'b1;
      end
    end
    nxt_stst  = (nxt_cnt == CNT_TOP);
    nxt_level = stst_ff ? cur_ff.hold : cur_ff.run;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_sync_ff      <= 3'h0;
      cnt_ff           <= '0;
      interval_ff      <= IV_MAX;
      upd_ff           <= 1'b0;
      stst_ff          <= 1'b0;
      current_level_ff <= RUN_RST;
    end else begin
      ext_sync_ff      <= {ext_sync_ff[1:0], step_ext};
      cnt_ff           <= nxt_cnt;
      interval_ff      <= nxt_interval;
      upd_ff           <= nxt_upd;
      stst_ff          <= nxt_stst;
      current_level_ff <= nxt_level;
    end
  end

  // ************************************************************
  // threshold comparators
  // ************************************************************
  hys_compare u_quiet (
    .aclk(aclk), .aresetn(aresetn), .upd(upd_ff),
    .interval(interval_ff), .limit(quiet_ff),
    .small_hys(gcfg_ff.small_hys), .above_ff(above_quiet_ff));
  hys_compare u_high (
    .aclk(aclk), .aresetn(aresetn), .upd(upd_ff),
    .interval(interval_ff), .limit(high_ff),
    .small_hys(gcfg_ff.small_hys), .above_ff(above_high_ff));
  hys_compare u_load (
    .aclk(aclk), .aresetn(aresetn), .upd(upd_ff),
    .interval(interval_ff), .limit(load_ff),
    .small_hys(gcfg_ff.small_hys), .above_ff(above_load_ff));

  // ************************************************************
  // checks
  // ************************************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  step_restart_a: assert property (step_evt |=> cnt_ff == '0)
    else $error("step did not restart interval count");
  step_norm_a: assert property (step_evt && cnt_ff < CNT_TOP
    && norm_cnt <= NORM_W'(IV_MAX)
    |=> interval_ff == $past(norm_cnt[INTERVAL_W-1:0]))
    else $error("interval not normalised on step");
  cmp_follow_a: assert property (upd_ff && interval_ff >= high_ff
    |=> !above_high_ff)
    else $error("high comparator stayed on above limit");
  stst_set_a: assert property (!step_evt && cnt_ff == CNT_TOP - 1'b1
    |=> stst_ff)
    else $error("standstill flag not set after count");
  stst_clr_a: assert property (step_evt |=> !stst_ff ##1 !stst_ff)
    else $error("standstill flag not cleared by step");
  level_sel_a: assert property (##1 current_level_ff ==
    ($past(stst_ff) ? $past(cur_ff.hold) : $past(cur_ff.run)))
    else $error("wrong current level for standstill state");

  step_cov_c: cover property (step_evt ##[1:50] step_evt);
  stst_cov_c: cover property ($rose(stst_ff));
  fast_cov_c: cover property ($rose(above_high_ff));

endmodule // velocity_mode_selector
`default_nettype wire

//--- verification/tb_velocity_mode_selector.sv
// self-checking testbench for the velocity mode selector
`timescale 1ns/1ps
`default_nettype none
module tb_velocity_mode_selector
  import velocity_mode_pkg::*;
;
  // ********************************************************
  // signals
  // ********************************************************
  localparam int STC = 64;
  logic                 aclk;
  logic                 aresetn;
  logic                 step_int;
  logic                 step_ext;
  logic [7:0]           s_axi_awaddr;
  logic [7:0]           s_axi_araddr;
  logic [31:0]          s_axi_wdata;
  logic [31:0]          s_axi_rdata;
  logic [31:0]          rdat;
  logic [3:0]           s_axi_wstrb;
  logic [1:0]           s_axi_bresp;
  logic [1:0]           s_axi_rresp;
  logic [1:0]           rsp;
  logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                 s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                 s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                 s_axi_rready, stst_ff, above_quiet_ff;
  logic                 above_high_ff, above_load_ff;
  logic [CURRENT_W-1:0] current_level_ff;
  int                   n_mismatch = 0;
  int                   checks_done = 0;

  // short standstill count keeps the run brief
  velocity_mode_selector #(.STST_COUNT(STC)) velocity_mode_selector_i (
    .aclk, .aresetn, .step_int, .step_ext, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stst_ff,
    .above_quiet_ff, .above_high_ff, .above_load_ff, .current_level_ff);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ********************************************************
  // helpers
  // ********************************************************
  task automatic conclude();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string w);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h want %h", $time, w, seen, exp);
    end
  endtask

  // one edge of a bounded wait
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200) begin
      n_mismatch++;
      $display("wrong value at %0t: wait ran out", $time);
      conclude();
    end
  endtask

  // bready and rready stay high, so the answer is taken when it shows
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do tick(n); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    do tick(n); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do tick(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do tick(n); while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rsp  = s_axi_rresp;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string w);
    rd(a);
    check(rdat, e, w);
  endtask

  // pulse taken gap edges after the previous one; returns two edges
  // later, where the comparators already show the new measurement
  task automatic step_gap(input int gap);
    repeat (gap - 3) @(posedge aclk);
    step_int <= 1'b1;
    @(posedge aclk);
    step_int <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic ext_gap(input int gap);
    repeat (gap - 3) @(posedge aclk);
    step_ext <= 1'b1;
    repeat (2) @(posedge aclk);
    step_ext <= 1'b0;
    @(posedge aclk);
  endtask

  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_reset();
    check(32'(current_level_ff), 32'(RUN_RST), "level");
    check(32'(stst_ff), 32'h0, "stst");
    rdc(ADDR_CURRENT, {19'h0, HOLD_RST, 3'h0, RUN_RST}, "current");
    rdc(ADDR_STEP_INTERVAL, 32'h000fffff, "interval");
    rdc(ADDR_STATUS, 32'h0, "status");
    rdc(ADDR_QUIET_LIMIT, 32'(LIMIT_RST), "limit");
  endtask

  task automatic t_regs();
    wr(ADDR_QUIET_LIMIT, 32'hffffffff, 4'hf);
    rdc(ADDR_QUIET_LIMIT, 32'h000fffff, "limit width");
    wr(8'h1c, 32'h1, 4'hf);
    check(32'(rsp), 32'(RESP_SLVERR), "wr resp");
    rdc(8'h1c, 32'h0, "unmapped");
    check(32'(rsp), 32'(RESP_SLVERR), "rd resp");
    wr(ADDR_STEP_INTERVAL, 32'h5, 4'hf);
    check(32'(rsp), 32'(RESP_OKAY), "ro resp");
    rdc(ADDR_STEP_INTERVAL, 32'h000fffff, "ro keep");
    wr(ADDR_CURRENT, 32'h00001f13, 4'h1);
    rdc(ADDR_CURRENT, 32'h00000813, "strobe");
    wr(ADDR_CURRENT, 32'h00000a13, 4'hf);
    rdc(ADDR_CURRENT, 32'h00000a13, "current");
  endtask

  task automatic t_measure();
    for (int c = 0; c < 5; c++) begin
      wr(ADDR_GLOBAL_CONFIG, 32'(c << GC_MRES_LSB), 4'hf);
      repeat (3) step_gap(48);
      rdc(ADDR_STEP_INTERVAL, 32'(48 >> c), "interval");
    end
    wr(ADDR_GLOBAL_CONFIG, 32'(1 << GC_EXT_STEP), 4'hf);
    repeat (3) ext_gap(40);
    repeat (4) @(posedge aclk);
    rdc(ADDR_STEP_INTERVAL, 32'h28, "ext interval");
  endtask

  task automatic t_hyst();
    int         gq[5] = '{46, 46, 44, 47, 48};
    logic [4:0] eq = 5'b01100;
    wr(ADDR_GLOBAL_CONFIG, 32'h0, 4'hf);
    wr(ADDR_QUIET_LIMIT, 32'h30, 4'hf);
    wr(ADDR_HIGH_LIMIT, 32'h28, 4'hf);
    wr(ADDR_LOAD_LIMIT, 32'h1e, 4'hf);
    for (int i = 0; i < 5; i++) begin
      step_gap(gq[i]);
      check(32'(above_quiet_ff), 32'(eq[i]), "quiet");
    end
    wr(ADDR_GLOBAL_CONFIG, 32'(1 << GC_SMALL_HYS), 4'hf);
    repeat (2) step_gap(46);
    check(32'(above_quiet_ff), 32'h1, "small hys");
    repeat (2) step_gap(35);
    check(32'({above_quiet_ff, above_high_ff, above_load_ff}), 32'h6,
          "three limits");
    repeat (2) step_gap(29);
    check(32'({above_quiet_ff, above_high_ff, above_load_ff}), 32'h7,
          "load limit");
    check(32'(current_level_ff), 32'h13, "run level");
    check(32'(stst_ff), 32'h0, "moving");
  endtask

  task automatic t_stst();
    int n;
    n = 0;
    do tick(n); while (stst_ff !== 1'b1);
    check(32'(n >= STC - 3 && n <= STC + 1), 32'h1, "stst delay");
    tick(n);
    check(32'({above_quiet_ff, above_high_ff, above_load_ff}), 32'h0,
          "drop");
    check(32'(current_level_ff), 32'h0a, "hold level");
    rdc(ADDR_STATUS, 32'h1, "status");
    rdc(ADDR_STEP_INTERVAL, 32'h000fffff, "idle interval");
    step_gap(3);
    repeat (2) @(posedge aclk);
    check(32'(stst_ff), 32'h0, "stst clear");
    check(32'(current_level_ff), 32'h13, "run again");
  endtask

  // ********************************************************
  // main sequence
  // ********************************************************
  initial begin
    aresetn       = 1'b0;
    step_int      = 1'b0;
    step_ext      = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'h0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b1;
    s_axi_araddr  = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_regs();
    t_measure();
    t_hyst();
    t_stst();
    conclude();
  end
endmodule // tb_velocity_mode_selector
`default_nettype wire
